//--- sbc_lin_pkg.sv
// Constants and types for the SPI register port and LIN fault logic
package sbc_lin_pkg;
   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_WAKE = 4'h2;
   localparam logic [3:0] ADDR_LIN = 4'h4;
   localparam logic [3:0] ADDR_HS = 4'h6;
   localparam logic [3:0] ADDR_TIM = 4'ha;
   localparam logic [3:0] ADDR_AMUX = 4'hc;
   localparam logic [3:0] ADDR_CFG = 4'hd;
   localparam logic [3:0] ADDR_IMASK = 4'he;
   localparam int MC_HVSE = 3;
   localparam int MC_PULLUP = 2;
   localparam int LC_DOMINANT_LEVEL_SELECT = 3;
   localparam int LC_RECEIVE_ONLY = 2;
   localparam int IM_HS = 3;
   localparam int IM_LIN = 1;
   localparam int IM_VOLT = 0;
   localparam int LS_SHORT = 3;
   localparam int LS_STUCK = 2;
   localparam int LS_OT = 1;
   localparam int LS_OC = 0;
   localparam int IS_HS = 3;
   localparam int IS_WAKE = 2;
   localparam int IS_LIN = 1;
   localparam int IS_VOLT = 0;
   localparam logic [3:0] MODE_CTRL_RST = 4'hc;
   localparam logic [3:0] WAKE_CTRL_RST = 4'hf;
   localparam logic [3:0] LIN_CTRL_RST = 4'h0;
   localparam logic [3:0] IMASK_RST = 4'h0;
   localparam logic [3:0] PLAIN_CTRL_RST = 4'h0;
   localparam logic [3:0] FRAME_BITS = 4'h8;
   localparam int CLOCK_MHZ = 40;
   localparam int TXD_STUCK_MS = 1000;
   localparam int TXD_STUCK_CYCLES = TXD_STUCK_MS * 1000 * CLOCK_MHZ;
   localparam int WAKE_FILTER_US = 100;
   localparam int WAKE_FILTER_CYCLES = WAKE_FILTER_US * CLOCK_MHZ;
   typedef enum logic [2:0] {
      MODE_NORMAL = 3'b001,
      MODE_STOP = 3'b010,
      MODE_SLEEP = 3'b100
   } op_mode_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [3:0] ctl;
   } spi_frame_t;
   typedef struct packed {
      logic csActive;
      logic overcurrent;
      logic overtemp;
      logic rxdShort;
      logic txd;
      logic linBus;
      logic l1;
      logic extReset;
      logic resetMode;
      logic [2:0] volt;
      logic [3:0] hs;
      logic [3:0] wd;
   } pin_in_t;
   localparam pin_in_t PIN_IDLE = '{txd: 1'b1, linBus: 1'b1, default: '0};
   typedef struct packed {
      logic [3:0] summary;
      logic [7:0][3:0] status;
   } read_image_t;
endpackage

//--- sbc_spi_regs_lin_fault_logic.sv
// SPI register port with LIN transceiver fault and wake logic
`timescale 1ns/100ps

// ----------------------------------------
// Pin synchroniser with agreement filter
// ----------------------------------------
module sync_filter #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1Reg;
   logic [W-1:0] s2Reg;
   logic [W-1:0] s3Reg;
   logic [W-1:0] qReg;
   logic [W-1:0] qNext;
   assign qNext = (s2Reg ^ s3Reg) & qReg | ~(s2Reg ^ s3Reg) & s3Reg;
   always_ff @(posedge clock) begin
      // Reset to each pin's idle level so no false edge follows reset
      if (!resetn) begin
         s1Reg <= INIT;
         s2Reg <= INIT;
         s3Reg <= INIT;
         qReg <= INIT;
      end else begin
         s1Reg <= d;
         s2Reg <= s1Reg;
         s3Reg <= s2Reg;
         qReg <= qNext;
      end
   end
   assign q = qReg;
endmodule

module sbc_spi_regs_lin_fault_logic
   import sbc_lin_pkg::*;
#(
   parameter int TXD_STUCK_LIMIT = TXD_STUCK_CYCLES
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic linSclk,
   input wire logic csN,
   input wire logic mosi,
   output logic misoOut,
   output logic misoOe,
   input wire logic txdIn,
   input wire logic linBusIn,
   input wire logic overcurrentIn,
   input wire logic overtempIn,
   input wire logic rxdShortIn,
   input wire logic l1In,
   input wire logic extResetN,
   input wire logic resetModeIn,
   input wire logic [2:0] voltIn,
   input wire logic [3:0] hsStatusIn,
   input wire logic [3:0] wdStatusIn,
   output logic receiveOutput,
   output logic linTxDominant,
   output logic linPullupOn,
   output logic busWakeThresholdSel,
   output logic dominantLevelSel,
   output logic [1:0] linSlewSel,
   output logic hvShutdownEn,
   output logic l1WakeEn,
   output logic [3:0] hsCtl,
   output logic [3:0] timCtl,
   output logic [3:0] amuxCtl,
   output logic [3:0] cfgCtl,
   output logic irqReq,
   output logic wdClear,
   output logic wakeReset
);
   // ----------------------------------------
   // Link side, on the serial clock
   // ----------------------------------------
   logic freshReg;
   logic tagReg;
   logic [7:0] rxShiftReg;
   logic [3:0] bitCountReg;
   logic [3:0] bitCountNext;
   logic [3:0] addrReg;
   logic misoReg;
   read_image_t imageReg;

   assign bitCountNext = freshReg ? 4'h1 :
      (bitCountReg == 4'hf) ? 4'hf : bitCountReg + 4'h1;

   // Marks the first sampling edge of each selection
   always_ff @(negedge linSclk or posedge csN or negedge resetn) begin
      if (csN || !resetn) begin
         freshReg <= 1'b1;
      end else begin
         freshReg <= 1'b0;
      end
   end

   always_ff @(negedge linSclk) begin
      rxShiftReg <= {rxShiftReg[6:0], mosi};
      bitCountReg <= bitCountNext;
   end

   // Toggles once per selection so a selection without edges is not taken
   always_ff @(negedge linSclk or negedge resetn) begin
      if (!resetn) begin
         tagReg <= 1'b0;
      end else begin
         tagReg <= tagReg ^ freshReg;
      end
   end

   always_ff @(negedge linSclk) begin
      if (bitCountNext == 4'h4) begin
         addrReg <= {rxShiftReg[2:0], mosi};
      end
   end

   logic [3:0] bitIdx;
   logic [3:0] selNib;
   logic txBit;
   assign bitIdx = freshReg ? 4'h0 : bitCountReg;
   assign selNib = imageReg.status[addrReg[3:1]];
   assign txBit = (bitIdx < 4'h4) ? imageReg.summary[2'd3 - bitIdx[1:0]] :
      (bitIdx < 4'h8) ? selNib[2'd3 - bitIdx[1:0]] : 1'b0;

   always_ff @(posedge linSclk) begin
      misoReg <= txBit;
   end

   assign misoOut = misoReg;
   assign misoOe = ~csN;

   // ----------------------------------------
   // Pin inputs
   // ----------------------------------------
   pin_in_t pinRaw;
   pin_in_t pf;
   assign pinRaw = '{csActive: ~csN, overcurrent: overcurrentIn, overtemp: overtempIn,
      rxdShort: rxdShortIn, txd: txdIn, linBus: linBusIn, l1: l1In,
      extReset: ~extResetN, resetMode: resetModeIn, volt: voltIn,
      hs: hsStatusIn, wd: wdStatusIn};

   sync_filter #(.W($bits(pin_in_t)), .INIT(PIN_IDLE)) pinSync (
      .clock(clock),
      .resetn(resetn),
      .d(pinRaw),
      .q(pf)
   );

   // ----------------------------------------
   // Frame commit
   // ----------------------------------------
   logic csPrevReg;
   logic seenTagReg;
   logic csEnd;
   logic frameOk;
   logic softReset;
   spi_frame_t frame;
   assign csEnd = csPrevReg & ~pf.csActive;
   assign frame = rxShiftReg;
   assign frameOk = csEnd & (tagReg != seenTagReg) & (bitCountReg == FRAME_BITS);
   assign softReset = pf.extReset | pf.resetMode;

   always_ff @(posedge clock) begin
      if (!resetn) begin
         csPrevReg <= 1'b0;
         seenTagReg <= 1'b0;
      end else begin
         csPrevReg <= pf.csActive;
         seenTagReg <= csEnd ? tagReg : seenTagReg;
      end
   end

   logic wrMode;
   logic wrWake;
   logic wrLin;
   logic wrImask;
   logic linRead;
   logic voltRead;
   logic isrRead;
   assign wrMode = frameOk & (frame.addr == ADDR_MODE);
   assign wrWake = frameOk & (frame.addr == ADDR_WAKE);
   assign wrLin = frameOk & (frame.addr == ADDR_LIN);
   assign wrImask = frameOk & (frame.addr == ADDR_IMASK);
   assign linRead = frameOk & (frame.addr[3:1] == ADDR_LIN[3:1]);
   assign voltRead = frameOk & (frame.addr[3:1] == ADDR_MODE[3:1]);
   assign isrRead = frameOk & (frame.addr[3:1] == ADDR_IMASK[3:1]);

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   logic [3:0] modeCtlReg;
   logic [3:0] wakeCtlReg;
   logic [3:0] linCtlReg;
   logic [3:0] linCtlNext;
   logic [3:0] imaskReg;
   logic [3:0] hsCtlReg;
   logic [3:0] timCtlReg;
   logic [3:0] amuxCtlReg;
   logic [3:0] cfgCtlReg;
   logic batFailReg;

   // Pull-up and high-voltage bits only return to reset at power-on
   always_ff @(posedge clock) begin
      if (!resetn) begin
         modeCtlReg <= MODE_CTRL_RST;
         batFailReg <= 1'b1;
      end else begin
         modeCtlReg <= wrMode ? frame.ctl : modeCtlReg;
         batFailReg <= batFailReg & ~voltRead;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn || softReset) begin
         wakeCtlReg <= WAKE_CTRL_RST;
         linCtlReg <= LIN_CTRL_RST;
         imaskReg <= IMASK_RST;
         hsCtlReg <= PLAIN_CTRL_RST;
         timCtlReg <= PLAIN_CTRL_RST;
         amuxCtlReg <= PLAIN_CTRL_RST;
         cfgCtlReg <= PLAIN_CTRL_RST;
      end else begin
         wakeCtlReg <= wrWake ? frame.ctl : wakeCtlReg;
         linCtlReg <= linCtlNext;
         imaskReg <= wrImask ? frame.ctl : imaskReg;
         hsCtlReg <= (frameOk && frame.addr == ADDR_HS) ? frame.ctl : hsCtlReg;
         timCtlReg <= (frameOk && frame.addr == ADDR_TIM) ? frame.ctl : timCtlReg;
         amuxCtlReg <= (frameOk && frame.addr == ADDR_AMUX) ? frame.ctl : amuxCtlReg;
         cfgCtlReg <= (frameOk && frame.addr == ADDR_CFG) ? frame.ctl : cfgCtlReg;
      end
   end

   // ----------------------------------------
   // LIN fault monitors
   // ----------------------------------------
   logic ocFlagReg;
   logic otFlagReg;
   logic shortFlagReg;
   logic stuckFlagReg;
   logic otOffReg;
   logic shortOffReg;
   logic stuckOffReg;
   logic autoRxOnlyReg;
   logic faultPrevReg;
   logic [25:0] stuckCountReg;
   logic stuckEvent;
   logic rxEdge;
   logic failGone;
   logic faultNow;
   logic faultEvent;
   logic [3:0] linStatus;

   assign stuckEvent = ~pf.txd & (stuckCountReg == 26'(TXD_STUCK_LIMIT - 1));
   assign failGone = ~otOffReg & ~shortOffReg & ~stuckOffReg;
   // Overcurrent leaves receive-only alone so the driver keeps running
   assign faultNow = pf.overtemp | pf.rxdShort | stuckEvent;
   assign faultEvent = faultNow & ~faultPrevReg;
   assign linStatus = {shortFlagReg, stuckFlagReg, otFlagReg, ocFlagReg};

   always_ff @(posedge clock) begin
      if (!resetn) begin
         stuckCountReg <= '0;
      end else if (pf.txd) begin
         stuckCountReg <= '0;
      end else if (!stuckEvent && stuckCountReg != 26'(TXD_STUCK_LIMIT)) begin
         stuckCountReg <= stuckCountReg + 26'h1;
      end
   end

   // Hardware set wins over a clearing read in the same cycle
   always_ff @(posedge clock) begin
      if (!resetn || softReset) begin
         ocFlagReg <= 1'b0;
         otFlagReg <= 1'b0;
         shortFlagReg <= 1'b0;
         stuckFlagReg <= 1'b0;
      end else begin
         ocFlagReg <= pf.overcurrent | ocFlagReg & ~(linRead & ~pf.overcurrent);
         otFlagReg <= pf.overtemp | otFlagReg & ~(linRead & ~pf.overtemp);
         shortFlagReg <= pf.rxdShort | shortFlagReg & ~(linRead & ~pf.rxdShort);
         stuckFlagReg <= stuckEvent | stuckFlagReg & ~(linRead & pf.txd);
      end
   end

   // A status read under the release condition gives the same release
   always_ff @(posedge clock) begin
      if (!resetn || softReset) begin
         otOffReg <= 1'b0;
         shortOffReg <= 1'b0;
         stuckOffReg <= 1'b0;
         faultPrevReg <= 1'b0;
         autoRxOnlyReg <= 1'b0;
      end else begin
         otOffReg <= pf.overtemp | otOffReg & ~pf.txd;
         shortOffReg <= pf.rxdShort | shortOffReg & ~(rxEdge & pf.txd);
         stuckOffReg <= stuckEvent | stuckOffReg & ~pf.txd;
         faultPrevReg <= faultNow;
         autoRxOnlyReg <= faultEvent | autoRxOnlyReg & ~failGone;
      end
   end

   // Receive-only follows software, is forced on errors, drops when they clear
   always_comb begin
      linCtlNext = wrLin ? frame.ctl : linCtlReg;
      if (autoRxOnlyReg && failGone) begin
         linCtlNext[LC_RECEIVE_ONLY] = 1'b0;
      end
      if (faultEvent) begin
         linCtlNext[LC_RECEIVE_ONLY] = 1'b1;
      end
   end

   // ----------------------------------------
   // Operating mode and LIN wake
   // ----------------------------------------
   op_mode_t modeReg;
   op_mode_t modeNext;
   logic wakeDisReg;
   logic busPrevReg;
   logic [12:0] domCountReg;
   logic lowPower;
   logic wakeEvent;
   logic txAllowed;
   assign lowPower = (modeReg != MODE_NORMAL);
   assign wakeEvent = lowPower & ~wakeDisReg & pf.linBus & ~busPrevReg &
      (domCountReg == 13'(WAKE_FILTER_CYCLES));
   assign txAllowed = (modeReg == MODE_NORMAL) & ~linCtlReg[LC_RECEIVE_ONLY] & failGone;

   always_comb begin
      modeNext = modeReg;
      if (wakeEvent) begin
         modeNext = MODE_NORMAL;
      end else if (wrMode) begin
         case (frame.ctl[1:0])
            2'b01: modeNext = MODE_STOP;
            2'b10: modeNext = MODE_SLEEP;
            default: modeNext = MODE_NORMAL;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn || softReset) begin
         modeReg <= MODE_NORMAL;
         wakeDisReg <= 1'b0;
      end else begin
         modeReg <= modeNext;
         wakeDisReg <= lowPower ? wakeDisReg : linCtlReg[LC_RECEIVE_ONLY];
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         busPrevReg <= 1'b1;
         domCountReg <= '0;
      end else begin
         busPrevReg <= pf.linBus;
         if (!lowPower || pf.linBus) begin
            domCountReg <= '0;
         end else if (domCountReg != 13'(WAKE_FILTER_CYCLES)) begin
            domCountReg <= domCountReg + 13'h1;
         end
      end
   end

   // ----------------------------------------
   // Interrupt source and pins
   // ----------------------------------------
   logic [3:0] isrReg;
   logic [3:0] isrSet;
   logic receiveReg;
   logic rxPrevReg;
   logic txDomReg;
   logic irqReg;
   logic wdClearReg;
   logic wakeResetReg;
   logic pullupReg;
   assign isrSet = {|pf.hs, wakeEvent, faultEvent | pf.overcurrent, |pf.volt};
   assign rxEdge = receiveReg ^ rxPrevReg;

   always_ff @(posedge clock) begin
      if (!resetn || softReset) begin
         isrReg <= 4'h0;
      end else begin
         isrReg <= isrSet | isrReg & ~{4{isrRead}};
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         receiveReg <= 1'b1;
         rxPrevReg <= 1'b1;
         txDomReg <= 1'b0;
         irqReg <= 1'b0;
         wdClearReg <= 1'b0;
         wakeResetReg <= 1'b0;
         pullupReg <= 1'b1;
      end else begin
         receiveReg <= (!lowPower || (modeReg == MODE_STOP && linCtlReg[LC_RECEIVE_ONLY])) ?
            pf.linBus : 1'b1;
         rxPrevReg <= receiveReg;
         txDomReg <= txAllowed & ~pf.txd;
         irqReg <= imaskReg[IM_LIN] & (|linStatus) | isrReg[IS_WAKE] |
            imaskReg[IM_VOLT] & (|pf.volt) | imaskReg[IM_HS] & (|pf.hs);
         wdClearReg <= wrMode & (frame.ctl[1:0] == 2'b11);
         wakeResetReg <= wakeEvent & (modeReg == MODE_SLEEP);
         pullupReg <= ~lowPower | modeCtlReg[MC_PULLUP];
      end
   end

   // ----------------------------------------
   // Read image, frozen while selected
   // ----------------------------------------
   logic [3:0] voltStatus;
   logic [3:0] wakeStatus;
   read_image_t imageNext;
   assign voltStatus = {pf.volt, batFailReg};
   assign wakeStatus = {3'h0, pf.l1 & wakeCtlReg[0]};
   assign imageNext.summary = {|voltStatus, |linStatus, |pf.hs, 1'b0};
   assign imageNext.status = {isrReg, 4'h0, pf.wd, 4'h0, pf.hs, linStatus,
      wakeStatus, voltStatus};

   always_ff @(posedge clock) begin
      if (!resetn) begin
         imageReg <= '0;
      end else if (!pf.csActive) begin
         imageReg <= imageNext;
      end
   end

   assign receiveOutput = receiveReg;
   assign linTxDominant = txDomReg;
   assign linPullupOn = pullupReg;
   assign busWakeThresholdSel = modeCtlReg[MC_PULLUP];
   assign hvShutdownEn = modeCtlReg[MC_HVSE];
   assign dominantLevelSel = linCtlReg[LC_DOMINANT_LEVEL_SELECT];
   assign linSlewSel = linCtlReg[1:0];
   assign l1WakeEn = wakeCtlReg[0];
   assign hsCtl = hsCtlReg;
   assign timCtl = timCtlReg;
   assign amuxCtl = amuxCtlReg;
   assign cfgCtl = cfgCtlReg;
   assign irqReq = irqReg;
   assign wdClear = wdClearReg;
   assign wakeReset = wakeResetReg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_oc_keeps_tx;
      @(posedge clock) disable iff (!resetn)
      pf.overcurrent && !softReset |=> ocFlagReg && !$rose(otOffReg | shortOffReg);
   endproperty
   a_oc_keeps_tx: assert property (p_oc_keeps_tx) else $error("overcurrent misflagged");

   property p_ot_stops;
      @(posedge clock) disable iff (!resetn)
      pf.overtemp && !softReset |=> otFlagReg && otOffReg ##1 !txDomReg;
   endproperty
   a_ot_stops: assert property (p_ot_stops) else $error("overtemp did not stop tx");

   property p_ot_release;
      @(posedge clock) disable iff (!resetn)
      otOffReg && !pf.overtemp && pf.txd |=> !otOffReg;
   endproperty
   a_ot_release: assert property (p_ot_release) else $error("overtemp not released");

   property p_short_read;
      @(posedge clock) disable iff (!resetn)
      linRead && !pf.rxdShort |=> !shortFlagReg;
   endproperty
   a_short_read: assert property (p_short_read) else $error("short flag not cleared");

   property p_stuck_set;
      @(posedge clock) disable iff (!resetn)
      stuckEvent && !softReset |=> stuckFlagReg && stuckOffReg ##1 !txDomReg;
   endproperty
   a_stuck_set: assert property (p_stuck_set) else $error("stuck not flagged");

   property p_stuck_release;
      @(posedge clock) disable iff (!resetn)
      linRead && pf.txd && !softReset |=> !stuckFlagReg && !stuckOffReg;
   endproperty
   a_stuck_release: assert property (p_stuck_release) else $error("stuck not cleared");

   property p_irq_lin;
      @(posedge clock) disable iff (!resetn)
      imaskReg[IM_LIN] && (|linStatus) |=> irqReq;
   endproperty
   a_irq_lin: assert property (p_irq_lin) else $error("lin irq missing");

   property p_bad_frame;
      @(posedge clock) disable iff (!resetn)
      csEnd && !frameOk && !softReset |=> $stable(imaskReg) && $stable(wakeCtlReg) &&
         $stable(batFailReg) && $stable(modeCtlReg);
   endproperty
   a_bad_frame: assert property (p_bad_frame) else $error("bad frame changed state");

   property p_commit;
      @(posedge clock) disable iff (!resetn)
      wrImask && !softReset |=> imaskReg == $past(frame.ctl);
   endproperty
   a_commit: assert property (p_commit) else $error("mask write lost");

   property p_battery_fail_flag;
      @(posedge clock) disable iff (!resetn)
      voltRead |=> !batFailReg;
   endproperty
   a_battery_fail_flag: assert property (p_battery_fail_flag) else $error("battery fail not cleared");

   property p_stop_wake;
      @(posedge clock) disable iff (!resetn)
      wakeEvent && modeReg == MODE_STOP && !softReset |=>
         isrReg[IS_WAKE] && modeReg == MODE_NORMAL ##1 irqReq;
   endproperty
   a_stop_wake: assert property (p_stop_wake) else $error("stop wake lost");

   property p_sleep_wake;
      @(posedge clock) disable iff (!resetn)
      wakeEvent && modeReg == MODE_SLEEP && !softReset |=> wakeReset && isrReg[IS_WAKE];
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake lost");
endmodule

//--- sbc_spi_regs_lin_fault_logic_tb.sv
// Self-checking bench for the SPI register port and LIN fault logic
`timescale 1ns/100ps
module sbc_spi_regs_lin_fault_logic_tb;
   import sbc_lin_pkg::*;
   logic clock, resetn, txdIn, linBusIn, overcurrentIn, overtempIn, rxdShortIn, l1In;
   logic extResetN, resetModeIn, battery_fail_flag, receiveOutput, linPullupOn;
   logic [2:0] voltIn;
   logic [3:0] hsStatusIn, wdStatusIn;
   logic linSclk, csN, mosi, misoOut, misoOe, linTxDominant, dominantLevelSel, irqReq;
   logic [7:0] rx;
   logic [3:0] odd [5] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'hb};
   int err_total = 0;
   int comparisons = 0;
   sbc_spi_regs_lin_fault_logic #(.TXD_STUCK_LIMIT(50)) dut_u (.clock, .resetn, .linSclk,
      .csN, .mosi, .misoOut, .misoOe, .txdIn, .linBusIn, .overcurrentIn, .overtempIn,
      .rxdShortIn, .l1In, .extResetN, .resetModeIn, .voltIn, .hsStatusIn, .wdStatusIn,
      .receiveOutput, .linTxDominant, .linPullupOn, .busWakeThresholdSel(),
      .dominantLevelSel, .linSlewSel(), .hvShutdownEn(), .l1WakeEn(), .hsCtl(), .timCtl(),
      .amuxCtl(), .cfgCtl(), .irqReq, .wdClear(), .wakeReset());
   spi_master_model mst_u (.linSclk, .csN, .mosi, .misoOut, .misoOe);
   // ---------------
   // Checking helpers
   // ---------------
   function automatic logic [7:0] expect_rd(input logic [3:0] a, input logic [3:0] lin);
      logic [3:0] v;
      v = {voltIn, battery_fail_flag};
      case (a[3:1])
         3'h0: expect_rd[3:0] = v;
         3'h1: expect_rd[3:0] = {3'h0, l1In};
         3'h2: expect_rd[3:0] = lin;
         3'h3: expect_rd[3:0] = hsStatusIn;
         3'h5: expect_rd[3:0] = wdStatusIn;
         default: expect_rd[3:0] = 4'h0;
      endcase
      expect_rd[7:4] = {|v, |lin, |hsStatusIn, 1'b0};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      if (got !== exp)
         err_total++;
   endtask
   task automatic conclude();
      if (err_total == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic hold(input logic t, input int n);
      @(negedge clock);
      txdIn = t;
      repeat (n) @(negedge clock);
   endtask
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      #400000;
      err_total++;
      conclude();
   end
   initial begin
      logic [3:0] a;
      void'($urandom(62));
      {resetn, overcurrentIn, overtempIn, rxdShortIn, resetModeIn} = 5'h00;
      {txdIn, linBusIn, extResetN, l1In, battery_fail_flag} = 5'h1f;
      {voltIn, hsStatusIn, wdStatusIn} = 11'h000;
      repeat (3) @(negedge clock);
      resetn = 1'b1;
      repeat (6) @(negedge clock);
      chk({7'h0, misoOe}, 8'h00);
      mst_u.xfer(8'h10, 8, rx);
      chk(rx, expect_rd(4'h1, 4'h0));
      battery_fail_flag = 1'b0;
      repeat (8) begin
         @(negedge clock);
         {voltIn, hsStatusIn, wdStatusIn, l1In} = 12'($urandom);
         a = odd[$urandom_range(4, 0)];
         repeat (6) @(negedge clock);
         mst_u.xfer({a, 4'h0}, 8, rx);
         chk(rx, expect_rd(a, 4'h0));
      end
      mst_u.xfer(8'h48, 7, rx);
      chk({7'h0, dominantLevelSel}, 8'h00);
      mst_u.xfer(8'h48, 8, rx);
      chk(rx, expect_rd(4'h4, 4'h0));
      chk({7'h0, dominantLevelSel}, 8'h01);
      @(negedge clock);
      {voltIn, hsStatusIn, wdStatusIn} = 11'h000;
      mst_u.xfer(8'he2, 8, rx);
      hold(1'b0, 8);
      chk({7'h0, linTxDominant}, 8'h01);
      overtempIn = 1'b1;
      repeat (8) @(negedge clock);
      chk({6'h0, linTxDominant, irqReq}, 8'h01);
      overtempIn = 1'b0;
      hold(1'b0, 8);
      chk({7'h0, linTxDominant}, 8'h00);
      hold(1'b1, 8);
      hold(1'b0, 8);
      chk({7'h0, linTxDominant}, 8'h01);
      hold(1'b1, 6);
      mst_u.xfer(8'h50, 8, rx);
      chk(rx, expect_rd(4'h5, 4'h2));
      mst_u.xfer(8'hf0, 8, rx);
      chk({4'h0, rx[3:0]}, 8'h02);
      hold(1'b0, 60);
      chk({6'h0, linTxDominant, irqReq}, 8'h01);
      hold(1'b1, 8);
      hold(1'b0, 8);
      chk({7'h0, linTxDominant}, 8'h01);
      hold(1'b1, 6);
      mst_u.xfer(8'h50, 8, rx);
      chk(rx, expect_rd(4'h5, 4'h4));
      mst_u.xfer(8'h50, 8, rx);
      chk(rx, expect_rd(4'h5, 4'h0));
      @(negedge clock);
      rxdShortIn = 1'b1;
      hold(1'b0, 8);
      chk({7'h0, linTxDominant}, 8'h00);
      rxdShortIn = 1'b0;
      hold(1'b0, 8);
      chk({7'h0, linTxDominant}, 8'h00);
      hold(1'b1, 6);
      linBusIn = 1'b0;
      hold(1'b1, 6);
      linBusIn = 1'b1;
      hold(1'b1, 6);
      hold(1'b0, 8);
      chk({7'h0, linTxDominant}, 8'h01);
      hold(1'b1, 6);
      mst_u.xfer(8'h50, 8, rx);
      chk(rx, expect_rd(4'h5, 4'h8));
      @(negedge clock);
      overcurrentIn = 1'b1;
      hold(1'b0, 8);
      chk({6'h0, linTxDominant, irqReq}, 8'h03);
      overcurrentIn = 1'b0;
      hold(1'b1, 6);
      mst_u.xfer(8'h50, 8, rx);
      chk(rx, expect_rd(4'h5, 4'h1));
      mst_u.xfer(8'h01, 8, rx);
      @(negedge clock);
      linBusIn = 1'b0;
      repeat (4008) @(negedge clock);
      chk({5'h0, linPullupOn, receiveOutput, irqReq}, 8'h02);
      linBusIn = 1'b1;
      repeat (8) @(negedge clock);
      chk({6'h0, linPullupOn, irqReq}, 8'h03);
      extResetN = 1'b0;
      repeat (6) @(negedge clock);
      extResetN = 1'b1;
      repeat (6) @(negedge clock);
      chk({6'h0, dominantLevelSel, irqReq}, 8'h00);
      conclude();
   end
endmodule

//--- spi_master_model.sv
// SPI master model sending frames of a chosen number of clock edges, up to one byte, on the link
`timescale 1ns/100ps
module spi_master_model (
   output logic linSclk,
   output logic csN,
   output logic mosi,
   input wire logic misoOut,
   input wire logic misoOe
);
   initial begin
      linSclk = 1'b0;
      csN = 1'b1;
      mosi = 1'b0;
   end
   // Clock stands still between frames; mosi flips once deselected
   task automatic xfer(input logic [7:0] tx, input int edges, output logic [7:0] rx);
      csN = 1'b0;
      #200;
      for (int i = 0; i < edges; i++) begin
         linSclk = 1'b1;
         mosi = tx[3'(7 - i)];
         #15;
         linSclk = 1'b0;
         rx = {rx[6:0], misoOe ? misoOut : 1'bx};
         #15;
      end
      csN = 1'b1;
      mosi = ~mosi;
      #300;
   endtask
endmodule
